// [src/cfg_header_pkg.sv]
// Purpose: constants and carriers for the second-function configuration header
// Assumes: config and memory requests arrive from a PCI front end on CLOCK
// Notes: offsets are byte addresses of aligned configuration words
package cfg_header_pkg;
   localparam logic [7:0] OFS_COMMAND = 8'h04;
   localparam logic [7:0] OFS_CLASS = 8'h08;
   localparam logic [7:0] OFS_HEADER = 8'h0c;
   localparam logic [7:0] OFS_BAR0 = 8'h10;
   localparam logic [7:0] OFS_SUBSYS = 8'h2c;
   localparam logic [7:0] OFS_CAP_PTR = 8'h34;
   localparam logic [7:0] OFS_INTR = 8'h3c;
   localparam logic [7:0] OFS_DEV_CTRL = 8'h40;

   localparam int CMD_SERR_BIT = 8;
   localparam int CMD_PERR_BIT = 6;
   localparam int CMD_MASTER_BIT = 2;
   localparam int CMD_MEM_BIT = 1;
   localparam logic [31:0] CMD_WMASK = 32'h0000_0146;

   localparam logic [23:0] CLASS_CODE = 24'h048000;
   localparam logic [7:0] HEADER_KIND = 8'h80;
   localparam logic [7:0] LAT_TIMER_RST = 8'h00;
   localparam logic [11:0] BAR_LOW_BITS = 12'h008;
   localparam int BAR_BASE_LSB = 12;
   localparam logic [7:0] CAP_PTR_VAL = 8'h44;
   localparam logic [7:0] MAX_LAT_VAL = 8'hff;
   localparam logic [7:0] MIN_GNT_VAL = 8'h04;
   localparam logic [7:0] INT_PIN_VAL = 8'h01;

   localparam int CTRL_COMPAT_A_BIT = 2;
   localparam int CTRL_COMPAT_B_BIT = 1;
   localparam int CTRL_UNLOCK_BIT = 0;
   localparam logic [7:0] CTRL_WMASK = 8'h07;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [31:0] SUBSYS_RST = 32'h0000_0000;

   localparam logic [2:0] MY_FUNCTION = 3'b001;
   localparam logic [1:0] CFG_TYPE0 = 2'b00;

   typedef struct packed {
      logic valid;
      logic idsel;
      logic [2:0] func;
      logic [1:0] ad_low;
      logic [5:0] dword;
      logic write;
      logic [3:0] be_n;
      logic [31:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } mem_req_t;
endpackage

// [src/sync_2ff.sv]
// Purpose: two-flop synchroniser with a constant reset value
// Assumes: rst_n is asynchronous and active low
// Notes: only the second flop is visible outside
`timescale 1ns/1ps
module sync_2ff #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);
   logic meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// [src/latency_counter.sv]
// Purpose: master latency timer
// Assumes: start is a one-cycle pulse at the start of a master tenure
// Notes: a zero load expires right after the start
`timescale 1ns/1ps
module latency_counter #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic active,
   input wire logic [WIDTH-1:0] load,
   output logic expired
);
   logic [WIDTH-1:0] count_r;

   // one decrement per bus clock while mastering
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= '0;
         expired <= 1'b0;
      end else if (start) begin
         count_r <= load;
         expired <= (load == '0);
      end else if (active) begin
         if (count_r > WIDTH'(1)) begin
            count_r <= count_r - WIDTH'(1);
            expired <= 1'b0;
         end else begin
            count_r <= '0;
            expired <= 1'b1;
         end
      end else begin
         expired <= 1'b0;
      end
   end
endmodule

// [src/cfg_header.sv]
// Purpose: configuration header of the multimedia function
// Assumes: CFG_IN and MEM_IN come from the PCI front end on CLOCK
// Notes: status half, capability structures and local registers other than the control byte at 0x40 live elsewhere
`timescale 1ns/1ps
module cfg_header
   import cfg_header_pkg::*;
#(
   parameter logic [7:0] REVISION_ID = 8'h01 // arbitrary value
) (
   input wire logic CLOCK,
   input wire logic NRST,
   input wire cfg_req_t CFG_IN,
   output logic CFG_ACK,
   output logic [31:0] CFG_RDATA,
   input wire mem_req_t MEM_IN,
   output logic MEM_CLAIM,
   input wire logic SERR_REQ,
   output logic SERR_DRIVE,
   input wire logic PERR_DET,
   output logic PERR_REPORT,
   input wire logic MASTER_REQ,
   output logic MASTER_GO,
   input wire logic MASTER_ACTIVE,
   input wire logic GNT_N,
   output logic MASTER_STOP,
   output logic CHIPSET_COMPAT_A_EN,
   output logic CHIPSET_COMPAT_B_EN,
   output logic SUBSYS_WRITE_UNLOCK,
   output logic [7:0] INT_LINE
);
   logic rst_n;
   logic gnt_n_s;
   logic lat_expired;
   logic active_d_r;
   logic [31:0] cmd_r;
   logic [7:0] lat_timer_r;
   logic [19:0] bar_base_r;
   logic [31:0] subsys_r;
   logic [7:0] int_line_r;
   logic [7:0] ctrl_r;
   logic hit;
   logic wr_hit;
   logic rd_hit;
   logic [7:0] byte_ofs;
   logic [31:0] rd_word;
   logic [31:0] bar_merged;

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wdata,
                                            input logic [3:0] be_n, input logic [31:0] wmask);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (!be_n[i]) begin
            res[i*8 +: 8] = (wdata[i*8 +: 8] & wmask[i*8 +: 8]) | (old[i*8 +: 8] & ~wmask[i*8 +: 8]);
         end
      end
      return res;
   endfunction

   sync_2ff #(.RESET_VAL(1'b0)) u_rst_sync (
      .clk(CLOCK),
      .rst_n(NRST),
      .d(1'b1),
      .q(rst_n)
   );

   sync_2ff #(.RESET_VAL(1'b1)) u_gnt_sync (
      .clk(CLOCK),
      .rst_n(rst_n),
      .d(GNT_N),
      .q(gnt_n_s)
   );

   // decode of a type-0 access to this function
   assign hit = CFG_IN.valid && CFG_IN.idsel && (CFG_IN.func == MY_FUNCTION) && (CFG_IN.ad_low == CFG_TYPE0);
   assign wr_hit = hit && CFG_IN.write;
   assign rd_hit = hit && !CFG_IN.write;
   assign byte_ofs = {CFG_IN.dword, 2'b00};
   // byte-merged base word, only the upper twenty bits are kept
   assign bar_merged = be_merge({bar_base_r, 12'h000}, CFG_IN.wdata, CFG_IN.be_n, 32'hffff_f000);

   // read mux is pure, nothing changes on a read
   always_comb begin
      rd_word = 32'h0000_0000;
      case (byte_ofs)
         OFS_COMMAND: rd_word = cmd_r & CMD_WMASK;
         OFS_CLASS: rd_word = {CLASS_CODE, REVISION_ID};
         OFS_HEADER: rd_word = {8'h00, HEADER_KIND, lat_timer_r, 8'h00};
         OFS_BAR0: rd_word = {bar_base_r, BAR_LOW_BITS};
         OFS_SUBSYS: rd_word = subsys_r;
         OFS_CAP_PTR: rd_word = {24'h000000, CAP_PTR_VAL};
         OFS_INTR: rd_word = {MAX_LAT_VAL, MIN_GNT_VAL, INT_PIN_VAL, int_line_r};
         OFS_DEV_CTRL: rd_word = {24'h000000, ctrl_r & CTRL_WMASK};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         CFG_ACK <= 1'b0;
         CFG_RDATA <= 32'h0000_0000;
      end else begin
         CFG_ACK <= hit;
         CFG_RDATA <= rd_hit ? rd_word : 32'h0000_0000;
      end
   end

   // command enables, other bits discarded
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         cmd_r <= 32'h0000_0000;
      end else if (wr_hit && byte_ofs == OFS_COMMAND) begin
         cmd_r <= be_merge(cmd_r, CFG_IN.wdata, CFG_IN.be_n, CMD_WMASK);
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         lat_timer_r <= LAT_TIMER_RST;
      end else if (wr_hit && byte_ofs == OFS_HEADER && !CFG_IN.be_n[1]) begin
         lat_timer_r <= CFG_IN.wdata[15:8];
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         bar_base_r <= 20'h00000;
      end else if (wr_hit && byte_ofs == OFS_BAR0) begin
         bar_base_r <= bar_merged[31:BAR_BASE_LSB];
      end
   end

   // word stays put while locked
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         subsys_r <= SUBSYS_RST;
      end else if (wr_hit && byte_ofs == OFS_SUBSYS && ctrl_r[CTRL_UNLOCK_BIT]) begin
         subsys_r <= be_merge(subsys_r, CFG_IN.wdata, CFG_IN.be_n, 32'hffff_ffff);
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         int_line_r <= 8'h00;
      end else if (wr_hit && byte_ofs == OFS_INTR && !CFG_IN.be_n[0]) begin
         int_line_r <= CFG_IN.wdata[7:0];
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_hit && byte_ofs == OFS_DEV_CTRL && !CFG_IN.be_n[0]) begin
         ctrl_r <= CFG_IN.wdata[7:0] & CTRL_WMASK;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         CHIPSET_COMPAT_A_EN <= 1'b0;
         CHIPSET_COMPAT_B_EN <= 1'b0;
         SUBSYS_WRITE_UNLOCK <= 1'b0;
         INT_LINE <= 8'h00;
      end else begin
         CHIPSET_COMPAT_A_EN <= ctrl_r[CTRL_COMPAT_A_BIT];
         CHIPSET_COMPAT_B_EN <= ctrl_r[CTRL_COMPAT_B_BIT];
         SUBSYS_WRITE_UNLOCK <= ctrl_r[CTRL_UNLOCK_BIT];
         INT_LINE <= int_line_r;
      end
   end

   // error signalling gates
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         SERR_DRIVE <= 1'b0;
         PERR_REPORT <= 1'b0;
      end else begin
         SERR_DRIVE <= SERR_REQ && cmd_r[CMD_SERR_BIT];
         PERR_REPORT <= PERR_DET && cmd_r[CMD_PERR_BIT];
      end
   end

   // target decode of the 4 kB window
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         MEM_CLAIM <= 1'b0;
      end else begin
         MEM_CLAIM <= MEM_IN.valid && cmd_r[CMD_MEM_BIT] &&
                      (MEM_IN.addr[31:BAR_BASE_LSB] == bar_base_r);
      end
   end

   // master side
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         MASTER_GO <= 1'b0;
         MASTER_STOP <= 1'b0;
         active_d_r <= 1'b0;
      end else begin
         MASTER_GO <= MASTER_REQ && cmd_r[CMD_MASTER_BIT];
         MASTER_STOP <= lat_expired && gnt_n_s && MASTER_ACTIVE;
         active_d_r <= MASTER_ACTIVE;
      end
   end

   latency_counter #(.WIDTH(8)) u_lat (
      .clk(CLOCK),
      .rst_n(rst_n),
      .start(MASTER_ACTIVE && !active_d_r),
      .active(MASTER_ACTIVE),
      .load(lat_timer_r),
      .expired(lat_expired)
   );

   a_serr_gated: assert property (@(posedge CLOCK) disable iff (!rst_n)
      SERR_DRIVE |-> $past(SERR_REQ) && $past(cmd_r[CMD_SERR_BIT]))
      else $error("system error driven while disabled");

   a_perr_gated: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (PERR_DET && !cmd_r[CMD_PERR_BIT]) |=> !PERR_REPORT)
      else $error("parity error reported while disabled");

   a_master_go_gated: assert property (@(posedge CLOCK) disable iff (!rst_n)
      MASTER_REQ |=> (MASTER_GO == $past(cmd_r[CMD_MASTER_BIT])))
      else $error("master start not following enable");

   a_mem_claim_gated: assert property (@(posedge CLOCK) disable iff (!rst_n)
      MEM_CLAIM |-> $past(cmd_r[CMD_MEM_BIT]) && $past(MEM_IN.addr[31:12]) == $past(bar_base_r))
      else $error("memory claim without enable or match");

   a_class_read: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (rd_hit && byte_ofs == OFS_CLASS) |=> CFG_ACK && CFG_RDATA[31:8] == 24'h048000)
      else $error("class code wrong");

   a_bar_low_fixed: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (rd_hit && byte_ofs == OFS_BAR0) |=> CFG_RDATA[11:0] == 12'h008)
      else $error("base address low bits wrong");

   a_subsys_locked: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (wr_hit && byte_ofs == OFS_SUBSYS && !ctrl_r[CTRL_UNLOCK_BIT]) |=> $stable(subsys_r))
      else $error("locked subsystem word changed");

   a_latency_stop: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (lat_expired && gnt_n_s && MASTER_ACTIVE) |=> MASTER_STOP)
      else $error("master not stopping after expiry");

   a_reserved_zero: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (rd_hit && byte_ofs == 8'h00) |=> CFG_RDATA == 32'h0000_0000)
      else $error("unimplemented word not zero");

   a_foreign_ignored: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (CFG_IN.valid && (!CFG_IN.idsel || CFG_IN.func != MY_FUNCTION || CFG_IN.ad_low != CFG_TYPE0)) |=> !CFG_ACK)
      else $error("access to other function answered");

   a_intr_consts: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (rd_hit && byte_ofs == OFS_INTR) |=> CFG_RDATA[31:8] == 24'hff0401)
      else $error("interrupt word constants wrong");

   a_ack_follows_hit: assert property (@(posedge CLOCK) disable iff (!rst_n)
      hit |=> CFG_ACK)
      else $error("decoded access not acknowledged");

   a_rdata_idle_zero: assert property (@(posedge CLOCK) disable iff (!rst_n)
      !rd_hit |=> CFG_RDATA == 32'h0000_0000)
      else $error("read data not zero outside a read");

   a_cmd_reserved_zero: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (rd_hit && byte_ofs == OFS_COMMAND) |=> (CFG_RDATA & ~CMD_WMASK) == 32'h0000_0000)
      else $error("unused command bits not zero");

   a_header_kind: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (rd_hit && byte_ofs == OFS_HEADER) |=>
         CFG_RDATA[23:16] == HEADER_KIND && CFG_RDATA[31:24] == 8'h00 && CFG_RDATA[7:0] == 8'h00)
      else $error("header type word wrong");

   a_lat_readback: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (rd_hit && byte_ofs == OFS_HEADER) |=> CFG_RDATA[15:8] == $past(lat_timer_r))
      else $error("latency timer read back wrong");

   a_lat_timer_write: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (wr_hit && byte_ofs == OFS_HEADER && !CFG_IN.be_n[1]) |=> lat_timer_r == $past(CFG_IN.wdata[15:8]))
      else $error("latency timer write lost");

   a_bar_base_write: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (wr_hit && byte_ofs == OFS_BAR0 && CFG_IN.be_n == 4'h0) |=> bar_base_r == $past(CFG_IN.wdata[31:12]))
      else $error("base address write lost");

   a_subsys_read: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (rd_hit && byte_ofs == OFS_SUBSYS) |=> CFG_RDATA == $past(subsys_r))
      else $error("subsystem word read wrong");

   a_subsys_unlocked: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (wr_hit && byte_ofs == OFS_SUBSYS && ctrl_r[CTRL_UNLOCK_BIT] && CFG_IN.be_n == 4'h0) |=>
         subsys_r == $past(CFG_IN.wdata))
      else $error("unlocked subsystem write lost");

   a_cap_ptr_read: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (rd_hit && byte_ofs == OFS_CAP_PTR) |=> CFG_RDATA == {24'h000000, CAP_PTR_VAL})
      else $error("capability pointer wrong");

   a_int_line_read: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (rd_hit && byte_ofs == OFS_INTR) |=> CFG_RDATA[7:0] == $past(int_line_r))
      else $error("interrupt line read wrong");

   a_int_line_out: assert property (@(posedge CLOCK) disable iff (!rst_n)
      INT_LINE == $past(int_line_r))
      else $error("interrupt line output stale");

   a_ctrl_write: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (wr_hit && byte_ofs == OFS_DEV_CTRL && !CFG_IN.be_n[0]) |=> ctrl_r == ($past(CFG_IN.wdata[7:0]) & CTRL_WMASK))
      else $error("control write lost");

   a_compat_a_out: assert property (@(posedge CLOCK) disable iff (!rst_n)
      CHIPSET_COMPAT_A_EN == $past(ctrl_r[CTRL_COMPAT_A_BIT]))
      else $error("compatibility mode a output wrong");

   a_compat_b_out: assert property (@(posedge CLOCK) disable iff (!rst_n)
      CHIPSET_COMPAT_B_EN == $past(ctrl_r[CTRL_COMPAT_B_BIT]))
      else $error("compatibility mode b output wrong");

   a_unlock_out: assert property (@(posedge CLOCK) disable iff (!rst_n)
      SUBSYS_WRITE_UNLOCK == $past(ctrl_r[CTRL_UNLOCK_BIT]))
      else $error("unlock output wrong");

   a_serr_off: assert property (@(posedge CLOCK) disable iff (!rst_n)
      !cmd_r[CMD_SERR_BIT] |=> !SERR_DRIVE)
      else $error("system error driven while disabled");

   a_master_go_off: assert property (@(posedge CLOCK) disable iff (!rst_n)
      !cmd_r[CMD_MASTER_BIT] |=> !MASTER_GO)
      else $error("master started while disabled");

   a_mem_claim_off: assert property (@(posedge CLOCK) disable iff (!rst_n)
      !cmd_r[CMD_MEM_BIT] |=> !MEM_CLAIM)
      else $error("memory claimed while disabled");

   a_stop_cause: assert property (@(posedge CLOCK) disable iff (!rst_n)
      MASTER_STOP |-> $past(MASTER_ACTIVE) && $past(lat_expired))
      else $error("master stop without expiry");

   a_read_no_effect: assert property (@(posedge CLOCK) disable iff (!rst_n)
      rd_hit |=> $stable(cmd_r) && $stable(subsys_r) && $stable(ctrl_r))
      else $error("read changed a register");
endmodule

// [bench/cfg_host_model.sv]
// Purpose: host bridge model issuing configuration cycles to the header
// Assumes: requests launch 1 ns after the rising edge, one pulse per access
// Notes: released write data flips to its inverse so stale values never match
`timescale 1ns/1ps
module cfg_host_model
   import cfg_header_pkg::*;
(
   input wire logic clk,
   output cfg_req_t cfg_in,
   input wire logic cfg_ack,
   input wire logic [31:0] cfg_rdata
);
   initial begin
      cfg_in = '0;
   end

   task automatic access(input logic sel, input logic [2:0] fn, input logic wr, input logic [7:0] ofs,
                         input logic [3:0] be_n, input logic [31:0] wd, output logic [31:0] rd, output logic ack);
      @(posedge clk);
      #1;
      cfg_in.valid = 1'b1;
      cfg_in.idsel = sel;
      cfg_in.func = fn;
      cfg_in.ad_low = CFG_TYPE0;
      cfg_in.dword = ofs[7:2];
      cfg_in.write = wr;
      cfg_in.be_n = be_n;
      cfg_in.wdata = wd;
      @(posedge clk);
      #1;
      ack = cfg_ack;
      rd = cfg_rdata;
      cfg_in.valid = 1'b0;
      cfg_in.idsel = 1'b0;
      cfg_in.wdata = ~wd;
   endtask
endmodule

// [bench/pci_function1_config_header_test.sv]
// Purpose: self-checking bench for the second-function configuration header
// Assumes: inputs change 1 ns after the rising edge of clk
// Notes: register map checked at reset and after all-ones writes
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; $display("FAIL %0t: got %h exp %h", $time, g, e); end end
module pci_function1_config_header_test;
   import cfg_header_pkg::*;
   localparam logic [7:0] REV = 8'h01; // arbitrary value
   localparam logic [7:0] OFS [9] = '{OFS_COMMAND, OFS_CLASS, OFS_HEADER, OFS_BAR0, OFS_SUBSYS, OFS_CAP_PTR,
                                      OFS_INTR, OFS_DEV_CTRL, 8'h14};
   localparam logic [31:0] RST_V [9] = '{32'h0, {24'h048000, REV}, 32'h0080_0000, 32'h0000_0008, 32'h0, 32'h44,
                                         32'hff04_0100, 32'h0, 32'h0};
   localparam logic [31:0] ONE_V [9] = '{32'h146, {24'h048000, REV}, 32'h0080_ff00, 32'hffff_f008, 32'h0, 32'h44,
                                         32'hff04_01ff, 32'h7, 32'h0};
   logic clk, nrst, cfg_ack, mem_claim, serr_req, serr_drive, perr_det, perr_report;
   logic master_req, master_go, master_active, gnt_n, master_stop, compat_a, compat_b, unlock, ack_v;
   logic [31:0] cfg_rdata, rd_v;
   logic [7:0] int_line;
   cfg_req_t cfg_in;
   mem_req_t mem_in;
   int mismatches, checked, cycles;

   cfg_header #(.REVISION_ID(REV)) uut (.CLOCK(clk), .NRST(nrst), .CFG_IN(cfg_in), .CFG_ACK(cfg_ack),
      .CFG_RDATA(cfg_rdata), .MEM_IN(mem_in), .MEM_CLAIM(mem_claim), .SERR_REQ(serr_req), .SERR_DRIVE(serr_drive),
      .PERR_DET(perr_det), .PERR_REPORT(perr_report), .MASTER_REQ(master_req), .MASTER_GO(master_go),
      .MASTER_ACTIVE(master_active), .GNT_N(gnt_n), .MASTER_STOP(master_stop), .CHIPSET_COMPAT_A_EN(compat_a),
      .CHIPSET_COMPAT_B_EN(compat_b), .SUBSYS_WRITE_UNLOCK(unlock), .INT_LINE(int_line));

   cfg_host_model host (.clk(clk), .cfg_in(cfg_in), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic results();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         results();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic cfg_wr(input logic [7:0] o, input logic [31:0] d, input logic [3:0] be = 4'h0);
      host.access(1'b1, MY_FUNCTION, 1'b1, o, be, d, rd_v, ack_v);
      `CHK(ack_v, 1'b1)
   endtask

   task automatic cfg_rd(input logic [7:0] o, input logic [31:0] e);
      host.access(1'b1, MY_FUNCTION, 1'b0, o, 4'h0, 32'h0, rd_v, ack_v);
      `CHK(ack_v, 1'b1)
      `CHK(rd_v, e)
   endtask

   task automatic mem_chk(input logic [31:0] a, input logic e);
      @(posedge clk);
      #1;
      mem_in = '{1'b1, a};
      @(posedge clk);
      #1;
      mem_in = '{1'b0, ~a};
      `CHK(mem_claim, e)
   endtask

   initial begin
      nrst = 1'b0;
      mem_in = '0;
      serr_req = 1'b0;
      perr_det = 1'b0;
      master_req = 1'b0;
      master_active = 1'b0;
      gnt_n = 1'b1;
      mismatches = 0;
      checked = 0;
      cycles = 0;
      tick(5);
      nrst = 1'b1;
      tick(3);
      for (int i = 0; i < 9; i++) cfg_rd(OFS[i], RST_V[i]);
      `CHK({compat_a, compat_b, unlock, int_line}, 11'h0)
      for (int i = 0; i < 9; i++) cfg_wr(OFS[i], 32'hffff_ffff);
      for (int i = 0; i < 9; i++) cfg_rd(OFS[i], ONE_V[i]);
      tick(2);
      `CHK({compat_a, compat_b, unlock, int_line}, 11'h7ff)
      cfg_wr(OFS_SUBSYS, 32'h1234_5678);
      cfg_rd(OFS_SUBSYS, 32'h1234_5678);
      cfg_wr(OFS_DEV_CTRL, 32'h0);
      cfg_wr(OFS_SUBSYS, 32'h0);
      cfg_rd(OFS_SUBSYS, 32'h1234_5678);
      host.access(1'b0, MY_FUNCTION, 1'b1, OFS_INTR, 4'h0, 32'h0, rd_v, ack_v);
      `CHK(ack_v, 1'b0)
      host.access(1'b1, 3'b000, 1'b1, OFS_INTR, 4'h0, 32'h0, rd_v, ack_v);
      `CHK(ack_v, 1'b0)
      cfg_wr(OFS_INTR, 32'h0, 4'hf);
      cfg_rd(OFS_INTR, 32'hff04_01ff);
      mem_chk(32'hffff_f010, 1'b1);
      mem_chk(32'hffff_f010, 1'b1);
      mem_chk(32'hfffe_f010, 1'b0);
      serr_req = 1'b1;
      perr_det = 1'b1;
      master_req = 1'b1;
      tick(2);
      `CHK({serr_drive, perr_report, master_go}, 3'b111)
      cfg_wr(OFS_COMMAND, 32'h0000_0044);
      tick(2);
      `CHK({serr_drive, perr_report, master_go}, 3'b011)
      cfg_wr(OFS_COMMAND, 32'h0000_0100);
      tick(2);
      `CHK({serr_drive, perr_report, master_go}, 3'b100)
      mem_chk(32'hffff_f010, 1'b0);
      cfg_wr(OFS_HEADER, 32'h0000_0300);
      cfg_rd(OFS_HEADER, 32'h0080_0300);
      gnt_n = 1'b0;
      master_active = 1'b1;
      tick(8);
      `CHK(master_stop, 1'b0)
      gnt_n = 1'b1;
      tick(4);
      `CHK(master_stop, 1'b1)
      master_active = 1'b0;
      tick(2);
      `CHK(master_stop, 1'b0)
      results();
   end
endmodule
